// >>> hw/bxl_dev.sv
// Bridge end: lock acquisition, forwarding, holding and release
`timescale 1ns/1ps
`default_nettype none
module bxl_dev
(
  input wire logic clk_sys,
  input wire logic rst,
  bxl_if.dev pb,
  input wire logic serr_en,
  input wire logic mabort_mode,
  input wire logic queue_empty,
  input wire logic s_lock_in_n,
  input wire logic s_bus_idle,
  output logic s_req_q,
  output logic s_lock_oe_q,
  output logic s_lock_out_n_q,
  output logic [3:0] s_cmd_q,
  output logic [31:0] s_addr_q,
  output logic [3:0] s_be_q,
  output logic s_par_q,
  output logic s_locked_q,
  input wire logic s_done,
  input wire bxl_pkg::bxl_rsp_t s_rsp,
  input wire logic [31:0] s_data,
  output logic prefetch_en_q,
  output logic sig_serr_q,
  output logic rcv_tabort_q,
  output logic rcv_mabort_q,
  output logic p_locked_q
);
  import bxl_pkg::*;

  // ----------------------------------------------------------------
  // Local decode
  // ----------------------------------------------------------------
  bxl_state_t st_q;
  logic [15:0] mto_q;
  logic [31:0] data_q;
  logic abort_t_q;
  logic lock_seq;
  logic match;
  logic dn_lock;
  logic plain_dn;

  assign lock_seq = pb.req_valid && !pb.p_lock_n;
  assign dn_lock = lock_seq && pb.req_down;
  assign plain_dn = pb.req_valid && pb.req_down;
  assign match = (pb.req_cmd == s_cmd_q) && (pb.req_addr == s_addr_q) && (pb.req_be == s_be_q);

  // ----------------------------------------------------------------
  // Lock state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q <= BXL_ST_IDLE;
      s_lock_oe_q <= 1'b0;
      s_lock_out_n_q <= 1'b1;
      s_req_q <= 1'b0;
      s_locked_q <= 1'b0;
      p_locked_q <= 1'b0;
      s_cmd_q <= 4'h0;
      s_addr_q <= 32'h0000_0000;
      s_be_q <= 4'h0;
      s_par_q <= 1'b0;
      data_q <= 32'h0000_0000;
      abort_t_q <= 1'b0;
      mto_q <= BXL_RST_CNT;
      pb.rsp <= BXL_RSP_NONE;
      pb.rsp_data <= 32'h0000_0000;
    end
    else
    begin
      pb.rsp <= BXL_RSP_NONE;
      case (st_q)
        BXL_ST_IDLE:
        begin
          s_lock_oe_q <= 1'b0;
          s_lock_out_n_q <= 1'b1;
          if (pb.req_valid && !pb.req_down)
            pb.rsp <= BXL_RSP_RETRY;
          else if (dn_lock && pb.req_first)
          begin
            if (pb.req_cmd != BXL_CMD_MEM_RD)
              pb.rsp <= BXL_RSP_MABORT;
            else if (!s_lock_in_n)
              pb.rsp <= BXL_RSP_RETRY;
            else
            begin
              s_cmd_q <= pb.req_cmd;
              s_addr_q <= pb.req_addr;
              s_be_q <= pb.req_be;
              s_par_q <= pb.req_par;
              pb.rsp <= BXL_RSP_RETRY;
              st_q <= BXL_ST_DRAIN;
            end
          end
          else if (plain_dn)
            pb.rsp <= (pb.req_cmd == BXL_CMD_MEM_WR) ? BXL_RSP_POSTED : BXL_RSP_RETRY;
        end
        BXL_ST_DRAIN:
        begin
          if (pb.req_valid)
            pb.rsp <= BXL_RSP_RETRY;
          if (queue_empty)
            st_q <= BXL_ST_WAIT_BUS;
        end
        BXL_ST_WAIT_BUS:
        begin
          if (pb.req_valid)
            pb.rsp <= BXL_RSP_RETRY;
          if (s_lock_in_n && s_bus_idle)
          begin
            s_req_q <= 1'b1;
            s_lock_oe_q <= 1'b1;
            s_lock_out_n_q <= 1'b1;
            st_q <= BXL_ST_ISSUE;
          end
        end
        BXL_ST_ISSUE:
        begin
          if (pb.req_valid)
            pb.rsp <= BXL_RSP_RETRY;
          s_lock_out_n_q <= 1'b0;
          if (s_done)
          begin
            s_req_q <= 1'b0;
            mto_q <= BXL_MTO_CYCLES;
            case (s_rsp)
              BXL_RSP_DATA:
              begin
                data_q <= s_data;
                s_locked_q <= 1'b1;
                st_q <= BXL_ST_READY;
              end
              BXL_RSP_TABORT, BXL_RSP_MABORT:
              begin
                abort_t_q <= (s_rsp == BXL_RSP_TABORT);
                s_lock_oe_q <= 1'b0;
                s_lock_out_n_q <= 1'b1;
                st_q <= BXL_ST_ABORTED;
              end
              default:
              begin
                s_lock_out_n_q <= 1'b1;
                s_req_q <= 1'b1;
                st_q <= BXL_ST_ISSUE;
              end
            endcase
          end
        end
        BXL_ST_READY:
        begin
          if (dn_lock && match)
          begin
            pb.rsp <= BXL_RSP_DATA;
            pb.rsp_data <= data_q;
            p_locked_q <= 1'b1;
            st_q <= BXL_ST_LOCKED;
          end
          else if (pb.req_valid)
            pb.rsp <= BXL_RSP_RETRY;
          if (!(dn_lock && match))
          begin
            if (mto_q == 16'h0001)
            begin
              s_lock_oe_q <= 1'b0;
              s_lock_out_n_q <= 1'b1;
              s_locked_q <= 1'b0;
              st_q <= BXL_ST_IDLE;
            end
            mto_q <= mto_q - 16'h0001;
          end
        end
        BXL_ST_LOCKED:
        begin
          s_lock_out_n_q <= 1'b0;
          if (s_done)
            s_req_q <= 1'b0;
          if (dn_lock)
          begin
            s_req_q <= 1'b1;
            s_cmd_q <= pb.req_cmd;
            s_addr_q <= pb.req_addr;
            s_be_q <= pb.req_be;
            pb.rsp <= (pb.req_cmd == BXL_CMD_MEM_WR) ? BXL_RSP_POSTED : BXL_RSP_RETRY;
          end
          else if (pb.req_valid)
            pb.rsp <= BXL_RSP_RETRY;
          // Release on LOCK# and FRAME# high with no secondary request pending
          if (pb.p_lock_n && pb.p_frame_n && !s_req_q)
          begin
            s_lock_oe_q <= 1'b0;
            s_lock_out_n_q <= 1'b1;
            s_locked_q <= 1'b0;
            p_locked_q <= 1'b0;
            st_q <= BXL_ST_IDLE;
          end
        end
        BXL_ST_ABORTED:
        begin
          if (dn_lock && match)
          begin
            pb.rsp <= abort_t_q ? BXL_RSP_TABORT : BXL_RSP_MABORT;
            st_q <= BXL_ST_IDLE;
          end
          else if (pb.req_valid)
            pb.rsp <= BXL_RSP_RETRY;
        end
        default:
          st_q <= BXL_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status and system error
  // ----------------------------------------------------------------
  logic serr_d;
  always_comb
  begin
    serr_d = 1'b0;
    if (st_q == BXL_ST_READY && mto_q == 16'h0001 && !(dn_lock && match))
      serr_d = serr_en;
    if (st_q == BXL_ST_LOCKED && s_done && s_cmd_q == BXL_CMD_MEM_WR)
    begin
      if (s_rsp == BXL_RSP_TABORT)
        serr_d = serr_en;
      if (s_rsp == BXL_RSP_MABORT)
        serr_d = serr_en && mabort_mode;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pb.p_serr_n <= 1'b1;
      sig_serr_q <= 1'b0;
      rcv_tabort_q <= 1'b0;
      rcv_mabort_q <= 1'b0;
      prefetch_en_q <= 1'b1;
    end
    else
    begin
      pb.p_serr_n <= !serr_d;
      if (serr_d)
        sig_serr_q <= 1'b1;
      if ((st_q == BXL_ST_ISSUE || st_q == BXL_ST_LOCKED) && s_done && s_rsp == BXL_RSP_TABORT)
        rcv_tabort_q <= 1'b1;
      if ((st_q == BXL_ST_ISSUE || st_q == BXL_ST_LOCKED) && s_done && s_rsp == BXL_RSP_MABORT)
        rcv_mabort_q <= 1'b1;
      prefetch_en_q <= (st_q == BXL_ST_IDLE);
    end
  end

endmodule : bxl_dev
`default_nettype wire

// >>> hw/bxl_pkg.sv
// Shared constants and types for the bridge exclusive-lock forwarding block
package bxl_pkg;

  // ----------------------------------------------------------------
  // PCI commands
  // ----------------------------------------------------------------
  localparam logic [3:0] BXL_CMD_IO_RD = 4'h2;
  localparam logic [3:0] BXL_CMD_IO_WR = 4'h3;
  localparam logic [3:0] BXL_CMD_MEM_RD = 4'h6;
  localparam logic [3:0] BXL_CMD_MEM_WR = 4'h7;
  localparam logic [3:0] BXL_CMD_CFG_RD = 4'ha;
  localparam logic [3:0] BXL_CMD_CFG_WR = 4'hb;

  // ----------------------------------------------------------------
  // Termination answers
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    BXL_RSP_NONE = 3'b000,
    BXL_RSP_RETRY = 3'b001,
    BXL_RSP_DATA = 3'b010,
    BXL_RSP_MABORT = 3'b011,
    BXL_RSP_TABORT = 3'b100,
    BXL_RSP_POSTED = 3'b101
  } bxl_rsp_t;

  // ----------------------------------------------------------------
  // Lock states of the device end
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    BXL_ST_IDLE = 3'b000,
    BXL_ST_DRAIN = 3'b001,
    BXL_ST_WAIT_BUS = 3'b010,
    BXL_ST_ISSUE = 3'b011,
    BXL_ST_READY = 3'b100,
    BXL_ST_LOCKED = 3'b101,
    BXL_ST_ABORTED = 3'b110
  } bxl_state_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int BXL_CLK_NS = 40;
  localparam int BXL_MTO_NS = 1000;
  localparam logic [15:0] BXL_MTO_CYCLES = 16'(BXL_MTO_NS / BXL_CLK_NS);
  localparam logic [15:0] BXL_RST_CNT = 16'h0000;

endpackage : bxl_pkg

// >>> hw/bxl_if.sv
// Interface joining the lock initiator and the bridge lock end
`timescale 1ns/1ps
`default_nettype none
interface bxl_if;
  import bxl_pkg::*;
  // Primary bus, transaction level with LOCK# and FRAME# pin levels
  logic req_valid;
  logic req_down;
  logic req_first;
  logic [3:0] req_cmd;
  logic [31:0] req_addr;
  logic [3:0] req_be;
  logic req_par;
  logic p_frame_n;
  logic p_lock_n;
  bxl_rsp_t rsp;
  logic [31:0] rsp_data;
  logic p_serr_n;

  modport dev
  (
    input req_valid, req_down, req_first, req_cmd, req_addr, req_be, req_par,
    input p_frame_n, p_lock_n,
    output rsp, rsp_data, p_serr_n
  );
  modport ini
  (
    output req_valid, req_down, req_first, req_cmd, req_addr, req_be, req_par,
    output p_frame_n, p_lock_n,
    input rsp, rsp_data, p_serr_n
  );
endinterface : bxl_if
`default_nettype wire

// >>> hw/bxl_ini.sv
// Primary initiator end: runs a locked sequence through the bridge
`timescale 1ns/1ps
`default_nettype none
module bxl_ini
(
  input wire logic clk_sys,
  input wire logic rst,
  bxl_if.ini pb,
  input wire logic start,
  input wire logic bus_idle,
  input wire logic [3:0] cmd,
  input wire logic [31:0] addr,
  input wire logic [3:0] be,
  input wire logic last,
  output logic busy_q,
  output logic done_q,
  output bxl_pkg::bxl_rsp_t result_q,
  output logic [31:0] data_q
);
  import bxl_pkg::*;

  // ----------------------------------------------------------------
  // Sequence control
  // ----------------------------------------------------------------
  logic phase_q;
  logic first_q;
  logic last_q;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pb.req_valid <= 1'b0;
      pb.req_down <= 1'b1;
      pb.req_first <= 1'b0;
      pb.req_cmd <= 4'h0;
      pb.req_addr <= 32'h0000_0000;
      pb.req_be <= 4'h0;
      pb.req_par <= 1'b0;
      pb.p_frame_n <= 1'b1;
      pb.p_lock_n <= 1'b1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      phase_q <= 1'b0;
      first_q <= 1'b1;
      last_q <= 1'b0;
      result_q <= BXL_RSP_NONE;
      data_q <= 32'h0000_0000;
    end
    else
    begin
      done_q <= 1'b0;
      pb.req_valid <= 1'b0;
      // Begin only when idle, LOCK# high for the first access, any LOCK# level for later ones
      if (!busy_q && start && bus_idle && (pb.p_lock_n || !first_q))
      begin
        busy_q <= 1'b1;
        phase_q <= 1'b0;
        last_q <= last;
        pb.req_cmd <= cmd;
        pb.req_addr <= addr;
        pb.req_be <= be;
        pb.req_par <= ^{cmd, addr, be};
        pb.req_first <= first_q;
        pb.p_frame_n <= 1'b0;
      end
      else if (busy_q && !phase_q)
      begin
        pb.p_lock_n <= 1'b0;
        pb.req_valid <= 1'b1;
        phase_q <= 1'b1;
      end
      else if (busy_q && pb.rsp != BXL_RSP_NONE)
      begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
        result_q <= pb.rsp;
        data_q <= pb.rsp_data;
        pb.p_frame_n <= 1'b1;
        if (pb.rsp == BXL_RSP_DATA || pb.rsp == BXL_RSP_POSTED)
          first_q <= 1'b0;
        // Drop lock after abort, last, or a retried first access
        if (pb.rsp == BXL_RSP_TABORT || pb.rsp == BXL_RSP_MABORT || last_q ||
            (first_q && pb.rsp == BXL_RSP_RETRY))
        begin
          pb.p_lock_n <= 1'b1;
          if (pb.rsp != BXL_RSP_RETRY)
            first_q <= 1'b1;
        end
      end
    end
  end

endmodule : bxl_ini
`default_nettype wire

// >>> verification/bxl_asserts.sv
// Checker for the lock handshake between initiator and bridge end
`timescale 1ns/1ps
`default_nettype none
module bxl_asserts
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic p_frame_n,
  input wire logic p_lock_n,
  input wire bxl_pkg::bxl_rsp_t rsp,
  input wire logic p_serr_n,
  input wire logic serr_en,
  input wire logic s_lock_in_n,
  input wire logic s_bus_idle,
  input wire logic s_lock_oe_q,
  input wire logic s_lock_out_n_q,
  input wire logic s_req_q,
  input wire logic sig_serr_q,
  input wire logic p_locked_q
);
  import bxl_pkg::*;
  // ----
  // Lock checks
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_lock_seq_p;
    p_lock_n ##1 !p_lock_n;
  endsequence
  sequence s_lock_seq_s;
    s_lock_out_n_q ##1 !s_lock_out_n_q;
  endsequence
  a_rsp_latency: assert property (req_valid |=> rsp != BXL_RSP_NONE)
    else $error("no answer one cycle after a request");
  a_addr_unlocked: assert property ($fell(p_frame_n) && $past(p_lock_n) |-> s_lock_seq_p)
    else $error("primary lock not taken one cycle after address");
  a_sec_lock_seq: assert property ($rose(s_lock_oe_q) |-> s_lock_seq_s)
    else $error("secondary lock not taken one cycle after address");
  a_sec_lock_wait: assert property ($rose(s_lock_oe_q) |-> $past(s_lock_in_n) && $past(s_bus_idle))
    else $error("secondary lock taken while busy or locked");
  a_serr_status: assert property ($fell(p_serr_n) |=> p_serr_n && sig_serr_q)
    else $error("system error without status flag");
  a_serr_gate: assert property (!p_serr_n |-> serr_en)
    else $error("system error while disabled");
  a_data_locks: assert property (rsp == BXL_RSP_DATA |-> ##[0:1] p_locked_q)
    else $error("read data without primary lock");
  a_abort_unlocks: assert property (rsp inside {BXL_RSP_TABORT, BXL_RSP_MABORT} |=> !p_locked_q)
    else $error("lock held after abort");
  a_release_prompt: assert property (p_locked_q && p_lock_n && p_frame_n && !s_req_q |-> ##[1:2] !s_lock_oe_q)
    else $error("secondary lock not released");
  a_post_release: assert property (p_locked_q && p_lock_n && p_frame_n && $fell(s_req_q) |-> ##1 !s_lock_oe_q)
    else $error("secondary lock kept after last posted write");
  a_reset_clear: assert property ($fell(rst) |-> !s_lock_oe_q && !p_locked_q && rsp == BXL_RSP_NONE)
    else $error("lock state left after reset");
endmodule : bxl_asserts
`default_nettype wire

// >>> verification/bxl_tb.sv
// Self-checking bench for the lock initiator and bridge lock end
`timescale 1ns/1ps
`default_nettype none
module bxl_tb;
  import bxl_pkg::*;
  localparam logic [31:0] DATA1 = 32'h5a3c_96e1;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic serr_en = 1'b1;
  logic queue_empty = 1'b0;
  logic other_lock_n = 1'b0;
  logic s_bus_idle = 1'b0;
  logic s_done = 1'b0;
  bxl_rsp_t s_rsp = BXL_RSP_NONE;
  logic [31:0] s_data = 32'h0;
  logic start = 1'b0;
  logic [3:0] cmd = 4'h0;
  logic [31:0] addr = 32'h0000_1a40;
  logic last = 1'b0;
  logic s_req_q, s_lock_oe_q, s_lock_out_n_q, s_locked_q, prefetch_en_q, sig_serr_q;
  logic rcv_tabort_q, rcv_mabort_q, p_locked_q, done_q;
  logic [3:0] s_cmd_q;
  logic [31:0] s_addr_q, data_q;
  bxl_rsp_t result_q;
  wire logic s_lock_in_n;
  int errors = 0, comparisons = 0, cycles = 0, serr_cnt = 0;
  logic [3:0] bad [5] = '{BXL_CMD_IO_RD, BXL_CMD_IO_WR, BXL_CMD_CFG_RD, BXL_CMD_CFG_WR,
    BXL_CMD_MEM_WR};
  // Shared secondary LOCK# wire, low if any party pulls it
  assign s_lock_in_n = other_lock_n & ~(s_lock_oe_q & ~s_lock_out_n_q);
  always #20 clk_sys = ~clk_sys;
  bxl_if i_bxl_if ();
  bxl_dev i_bxl_dev
  (
    .clk_sys(clk_sys), .rst(rst), .pb(i_bxl_if.dev), .serr_en(serr_en),
    .mabort_mode(1'b1), .queue_empty(queue_empty), .s_lock_in_n(s_lock_in_n),
    .s_bus_idle(s_bus_idle), .s_req_q(s_req_q), .s_lock_oe_q(s_lock_oe_q),
    .s_lock_out_n_q(s_lock_out_n_q), .s_cmd_q(s_cmd_q), .s_addr_q(s_addr_q), .s_be_q(),
    .s_par_q(), .s_locked_q(s_locked_q), .s_done(s_done), .s_rsp(s_rsp), .s_data(s_data),
    .prefetch_en_q(prefetch_en_q), .sig_serr_q(sig_serr_q), .rcv_tabort_q(rcv_tabort_q),
    .rcv_mabort_q(rcv_mabort_q), .p_locked_q(p_locked_q)
  );
  bxl_ini i_bxl_ini
  (
    .clk_sys(clk_sys), .rst(rst), .pb(i_bxl_if.ini), .start(start), .bus_idle(1'b1),
    .cmd(cmd), .addr(addr), .be(4'hf), .last(last), .busy_q(), .done_q(done_q),
    .result_q(result_q), .data_q(data_q)
  );
  bxl_asserts i_bxl_asserts
  (
    .clk_sys(clk_sys), .rst(rst), .req_valid(i_bxl_if.req_valid),
    .p_frame_n(i_bxl_if.p_frame_n), .p_lock_n(i_bxl_if.p_lock_n), .rsp(i_bxl_if.rsp),
    .p_serr_n(i_bxl_if.p_serr_n), .serr_en(serr_en), .s_lock_in_n(s_lock_in_n),
    .s_bus_idle(s_bus_idle), .s_lock_oe_q(s_lock_oe_q), .s_lock_out_n_q(s_lock_out_n_q),
    .s_req_q(s_req_q), .sig_serr_q(sig_serr_q), .p_locked_q(p_locked_q)
  );
  // ----
  // Tasks
  // ----
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic run(input logic [3:0] c, input logic l, input bxl_rsp_t exp);
    int n;
    n = 0;
    @(posedge clk_sys);
    start <= 1'b1;
    cmd <= c;
    last <= l;
    @(posedge clk_sys);
    start <= 1'b0;
    while (done_q !== 1'b1 && n < 40)
    begin
      step(1);
      n++;
    end
    check("answer", 32'(result_q), 32'(exp));
  endtask : run
  task automatic sec(input bxl_rsp_t r, input logic [31:0] d);
    int n;
    n = 0;
    while (s_req_q !== 1'b1 && n < 40)
    begin
      step(1);
      n++;
    end
    check("secondary request", 32'(n < 40), 32'h1);
    @(posedge clk_sys);
    s_done <= 1'b1;
    s_rsp <= r;
    s_data <= d;
    @(posedge clk_sys);
    s_done <= 1'b0;
    s_rsp <= BXL_RSP_NONE;
    step(1);
  endtask : sec
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk_sys)
    if (!rst && i_bxl_if.p_serr_n === 1'b0)
      serr_cnt <= serr_cnt + 1;
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      wrap_up();
    end
  end
  // ----
  // Tests
  // ----
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    step(1);
    check("lock drive", 32'(s_lock_oe_q), 32'h0);
    check("prefetch", 32'(prefetch_en_q), 32'h1);
    check("serr pin", 32'(i_bxl_if.p_serr_n), 32'h1);
    $display("test reset done");
    foreach (bad[i]) run(bad[i], 1'b0, BXL_RSP_MABORT);
    $display("test first command done");
    run(BXL_CMD_MEM_RD, 1'b0, BXL_RSP_RETRY);
    check("no capture", 32'(s_cmd_q), 32'h0);
    @(posedge clk_sys) other_lock_n <= 1'b1;
    run(BXL_CMD_MEM_RD, 1'b0, BXL_RSP_RETRY);
    check("captured addr", s_addr_q, addr);
    @(posedge clk_sys) other_lock_n <= 1'b0;
    run(BXL_CMD_IO_WR, 1'b0, BXL_RSP_RETRY);
    check("captured cmd", 32'(s_cmd_q), 32'(BXL_CMD_MEM_RD));
    step(3);
    check("drain wait", 32'(s_req_q), 32'h0);
    @(posedge clk_sys) queue_empty <= 1'b1;
    step(3);
    check("lock wait", 32'(s_req_q), 32'h0);
    @(posedge clk_sys) other_lock_n <= 1'b1;
    step(3);
    check("idle wait", 32'(s_req_q), 32'h0);
    @(posedge clk_sys) s_bus_idle <= 1'b1;
    sec(BXL_RSP_RETRY, 32'h0);
    sec(BXL_RSP_DATA, DATA1);
    check("secondary lock", 32'(s_locked_q), 32'h1);
    run(BXL_CMD_MEM_RD, 1'b0, BXL_RSP_DATA);
    check("read data", data_q, DATA1);
    check("primary lock", 32'(p_locked_q), 32'h1);
    check("prefetch", 32'(prefetch_en_q), 32'h0);
    run(BXL_CMD_MEM_WR, 1'b0, BXL_RSP_POSTED);
    sec(BXL_RSP_TABORT, 32'h0);
    check("lock held", 32'(s_lock_out_n_q), 32'h0);
    check("serr count", 32'(serr_cnt), 32'h1);
    check("serr flag", 32'(sig_serr_q), 32'h1);
    check("tabort flag", 32'(rcv_tabort_q), 32'h1);
    run(BXL_CMD_MEM_WR, 1'b1, BXL_RSP_POSTED);
    sec(BXL_RSP_DATA, 32'h0);
    check("lock drive", 32'(s_lock_oe_q), 32'h0);
    check("primary lock", 32'(p_locked_q), 32'h0);
    $display("test locked sequence done");
    run(BXL_CMD_MEM_RD, 1'b0, BXL_RSP_RETRY);
    sec(BXL_RSP_MABORT, 32'h0);
    run(BXL_CMD_MEM_RD, 1'b0, BXL_RSP_MABORT);
    check("mabort flag", 32'(rcv_mabort_q), 32'h1);
    check("lock drive", 32'(s_lock_oe_q), 32'h0);
    run(BXL_CMD_MEM_RD, 1'b0, BXL_RSP_RETRY);
    sec(BXL_RSP_DATA, DATA1);
    step(30);
    check("serr count", 32'(serr_cnt), 32'h2);
    check("lock drive", 32'(s_lock_oe_q), 32'h0);
    $display("test abort and timeout done");
    wrap_up();
  end
endmodule : bxl_tb
`default_nettype wire
